// ### logic/pwd_drivers.sv
// four pulse-width outputs: high-current open-drain driver, two push-pull
// outputs and a dimmed LED open-drain output, behind an 8-bit register port.
// assumes the host serial interface turns bus cycles into regWrEn/regRdEn strobes.
module pwd_drivers #(
  parameter int CLK_HZ = pwd_pkg::CLK_HZ_DEF
) (
  input wire logic ref_clk, // 250 MHz clock
  input wire logic rst_b, // async reset, active low
  input wire logic [7:0] regAddr, // register address
  input wire logic [7:0] regWrData, // write data
  input wire logic regWrEn, // write strobe
  input wire logic regRdEn, // read strobe
  output logic [7:0] regRdData, // read data, valid the cycle after regRdEn
  output logic hcDrvOut, // high-current pin output value (always low)
  output logic hcDrvOe, // high-current pin sinking
  output logic push_pull_out_a, // push-pull output a
  output logic push_pull_out_b, // push-pull output b
  output logic ledDrvOut, // LED pin output value (always low)
  output logic ledDrvOe // LED pin sinking
);

  localparam int CW = pwd_pkg::CNT_W;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int PP_PERIOD = CLK_HZ / pwd_pkg::PP_RATE_HZ;
  localparam int LED_SUB_PERIOD = CLK_HZ / (pwd_pkg::LED_RATE_HZ * pwd_pkg::LED_SUBS);
  localparam int HC_W = 16;
  localparam int LED_W = 17;

  typedef struct packed {
    logic [7:0] ledReg;
    logic [7:0] ppaReg;
    logic [7:0] hcReg;
    logic [7:0] ppbReg;
    logic [7:0] rdData;
    logic [3:0] hcSlot;
    logic [2:0] hcFreq;
    logic [3:0] hcDuty;
    logic hcOe;
    logic [1:0][7:0] ppSet;
    logic [1:0][CW-1:0] ppCnt;
    logic [1:0] ppOut;
    logic [7:0] ledSet;
    logic [3:0] ledSub;
    logic ledOe;
  } pwd_state_t;

  pwd_state_t st_reg;
  pwd_state_t st_next;

  // ----------------------------------------
  // timing tables
  // ----------------------------------------
  logic [HC_W-1:0] hcSlotTab [8];
  logic [CW-1:0] ppOn0Tab [8];
  logic [CW-1:0] ppOff0Tab [8];
  logic [CW-1:0] ppOn1Tab [8];
  logic [CW-1:0] ppOff1Tab [8];

  for (genvar g = 0; g < 8; g++) begin : gTab
    // sixteen duty slots make one output period
    assign hcSlotTab[g] = HC_W'(CLK_HZ / (pwd_pkg::HC_SLOTS * pwd_pkg::HC_FREQ_HZ[g]));
    assign ppOn0Tab[g] = CW'(pwd_pkg::us2cyc(pwd_pkg::PP_ON0_US[g], CLK_HZ));
    assign ppOff0Tab[g] = CW'(pwd_pkg::us2cyc(pwd_pkg::PP_OFF0_US[g], CLK_HZ));
    assign ppOn1Tab[g] = CW'(pwd_pkg::us2cyc(pwd_pkg::PP_ON1_US[g], CLK_HZ));
    assign ppOff1Tab[g] = CW'(pwd_pkg::us2cyc(pwd_pkg::PP_OFF1_US[g], CLK_HZ));
  end

  // ----------------------------------------
  // high-current driver slot divider
  // ----------------------------------------
  logic hcEn;
  logic hcTick;

  assign hcEn = st_reg.hcReg[pwd_pkg::HC_EN_BIT];

  pwd_tick_div #(
    .CNT_W(HC_W)
  ) uHcDiv (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clear(!hcEn),
    .load(hcSlotTab[st_reg.hcFreq]),
    .count(),
    .tick(hcTick)
  );

  // ----------------------------------------
  // LED sub-period divider
  // ----------------------------------------
  logic [LED_W-1:0] ledCnt;
  logic ledTick;
  logic [CW-1:0] ledSubOn;

  pwd_tick_div #(
    .CNT_W(LED_W)
  ) uLedDiv (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clear(1'b0),
    .load(LED_W'(LED_SUB_PERIOD)),
    .count(ledCnt),
    .tick(ledTick)
  );

  // each of the sixteen sub-pulses carries a sixteenth of the total on time;
  // settings whose total exceeds the period simply saturate to full on
  assign ledSubOn = CW'((32'(st_reg.ledSet) * CYC_PER_MS)
                        / (pwd_pkg::LED_WIDTH_SETTING_DIV * pwd_pkg::LED_SUBS));

  // ----------------------------------------
  // push-pull per-channel timing
  // ----------------------------------------
  logic [1:0][CW-1:0] ppOnC;
  logic [1:0][CW-1:0] ppPer;
  logic [1:0] ppFull;

  for (genvar ch = 0; ch < 2; ch++) begin : gPp
    logic [7:0] set;
    logic [2:0] onCode;
    logic [2:0] offCode;
    assign set = st_reg.ppSet[ch];
    assign onCode = set[pwd_pkg::PP_ON_LSB +: 3];
    assign offCode = set[pwd_pkg::PP_OFF_LSB +: 3];
    assign ppOnC[ch] = !set[pwd_pkg::PP_MODE_BIT]
                       ? CW'((32'(set[6:0]) * CYC_PER_MS) / pwd_pkg::PP_SET_DIV)
                       : set[pwd_pkg::PP_RANGE_BIT] ? ppOn1Tab[onCode]
                       : ppOn0Tab[onCode];
    assign ppPer[ch] = !set[pwd_pkg::PP_MODE_BIT] ? CW'(PP_PERIOD)
                       : set[pwd_pkg::PP_RANGE_BIT] ? ppOnC[ch] + ppOff1Tab[offCode]
                       : ppOnC[ch] + ppOff0Tab[offCode];
    assign ppFull[ch] = !set[pwd_pkg::PP_MODE_BIT] && set[6:0] == pwd_pkg::PP_SET_FULL;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    // register port
    if (regWrEn) begin
      if (regAddr == pwd_pkg::ADDR_LED_WIDTH) begin
        st_next.ledReg = regWrData;
      end else if (regAddr == pwd_pkg::ADDR_PP_A_CTRL) begin
        st_next.ppaReg = regWrData;
      end else if (regAddr == pwd_pkg::ADDR_HC_CTRL) begin
        st_next.hcReg = regWrData;
      end else if (regAddr == pwd_pkg::ADDR_PP_B_CTRL) begin
        st_next.ppbReg = regWrData;
      end
    end
    if (regRdEn) begin
      if (regAddr == pwd_pkg::ADDR_LED_WIDTH) begin
        st_next.rdData = st_reg.ledReg;
      end else if (regAddr == pwd_pkg::ADDR_PP_A_CTRL) begin
        st_next.rdData = st_reg.ppaReg;
      end else if (regAddr == pwd_pkg::ADDR_HC_CTRL) begin
        st_next.rdData = st_reg.hcReg;
      end else if (regAddr == pwd_pkg::ADDR_PP_B_CTRL) begin
        st_next.rdData = st_reg.ppbReg;
      end else begin
        st_next.rdData = pwd_pkg::RD_UNMAPPED;
      end
    end

    // high-current driver: settings are copied while idle so enabling
    // starts straight on the programmed values
    if (!hcEn) begin
      st_next.hcSlot = '0;
      // take the incoming write too, so the enabling write brings its own fields
      st_next.hcFreq = st_next.hcReg[pwd_pkg::HC_FREQ_LSB +: 3];
      st_next.hcDuty = st_next.hcReg[pwd_pkg::HC_DUTY_LSB +: 4];
    end else if (hcTick) begin
      st_next.hcSlot = st_reg.hcSlot + 4'h1;
      if (st_reg.hcSlot == 4'hf) begin
        st_next.hcFreq = st_reg.hcReg[pwd_pkg::HC_FREQ_LSB +: 3];
        st_next.hcDuty = st_reg.hcReg[pwd_pkg::HC_DUTY_LSB +: 4];
      end
    end
    st_next.hcOe = hcEn && (st_reg.hcSlot <= st_reg.hcDuty);

    // push-pull channels
    for (int i = 0; i < 2; i++) begin
      if (st_reg.ppCnt[i] >= ppPer[i] - CW'(1)) begin
        st_next.ppCnt[i] = '0;
        st_next.ppSet[i] = (i == 0) ? st_reg.ppaReg : st_reg.ppbReg;
      end else begin
        st_next.ppCnt[i] = st_reg.ppCnt[i] + CW'(1);
      end
      st_next.ppOut[i] = ppFull[i] || (st_reg.ppCnt[i] < ppOnC[i]);
    end

    // LED output
    if (ledTick) begin
      st_next.ledSub = st_reg.ledSub + 4'h1;
      if (st_reg.ledSub == 4'hf) begin
        st_next.ledSet = st_reg.ledReg;
      end
    end
    st_next.ledOe = (st_reg.ledSet == pwd_pkg::LED_WIDTH_SETTING_FULL)
                    || (CW'(ledCnt) < ledSubOn);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
      st_reg.ledReg <= pwd_pkg::RST_LED_WIDTH;
      st_reg.ppaReg <= pwd_pkg::RST_PP_A_CTRL;
      st_reg.hcReg <= pwd_pkg::RST_HC_CTRL;
      st_reg.ppbReg <= pwd_pkg::RST_PP_B_CTRL;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign regRdData = st_reg.rdData;
  assign hcDrvOut = 1'b0;
  assign hcDrvOe = st_reg.hcOe;
  assign push_pull_out_a = st_reg.ppOut[0];
  assign push_pull_out_b = st_reg.ppOut[1];
  assign ledDrvOut = 1'b0;
  assign ledDrvOe = st_reg.ledOe;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  property p_hc_off;
    !hcEn |=> !hcDrvOe;
  endproperty
  a_hc_off: assert property (p_hc_off) else $error("driver sinks while disabled");

  property p_hc_held;
    !hcEn |=> st_reg.hcSlot == 4'h0;
  endproperty
  a_hc_held: assert property (p_hc_held) else $error("slot counter runs while disabled");

  property p_hc_full;
    hcEn && st_reg.hcDuty == 4'hf ##1 hcEn |=> hcDrvOe;
  endproperty
  a_hc_full: assert property (p_hc_full) else $error("full duty not continuous");

  property p_hc_low_duty;
    hcEn && st_reg.hcDuty == 4'h0 && st_reg.hcSlot == 4'h3 |=> !hcDrvOe;
  endproperty
  a_hc_low_duty: assert property (p_hc_low_duty) else $error("minimum duty too long");

  property p_hc_latch;
    hcEn && $past(hcEn) && st_reg.hcDuty != $past(st_reg.hcDuty)
      |-> $past(hcTick) && $past(st_reg.hcSlot) == 4'hf;
  endproperty
  a_hc_latch: assert property (p_hc_latch) else $error("duty changed mid period");

  property p_pp_full;
    ppFull[0] |=> push_pull_out_a;
  endproperty
  a_pp_full: assert property (p_pp_full) else $error("setting 127 not always on");

  property p_pp_zero;
    st_reg.ppSet[1] == 8'h00 ##1 st_reg.ppSet[1] == 8'h00 |-> !push_pull_out_b;
  endproperty
  a_pp_zero: assert property (p_pp_zero) else $error("zero setting gives a pulse");

  property p_pp_boundary;
    $changed(st_reg.ppSet[0]) |-> $past(st_reg.ppCnt[0]) == ppPer[0] - CW'(1)
      || $past(st_reg.ppCnt[0]) >= $past(ppPer[0]) - CW'(1);
  endproperty
  a_pp_boundary: assert property (p_pp_boundary) else $error("setting taken mid period");

  property p_led_full;
    st_reg.ledSet == pwd_pkg::LED_WIDTH_SETTING_FULL |=> ledDrvOe;
  endproperty
  a_led_full: assert property (p_led_full) else $error("LED 255 not always on");

  property p_led_zero;
    st_reg.ledSet == 8'h00 |=> !ledDrvOe;
  endproperty
  a_led_zero: assert property (p_led_zero) else $error("LED zero setting pulses");

  c_hc_pulse: cover property (hcEn && !hcDrvOe ##1 hcDrvOe);
  c_pp_mode1: cover property (st_reg.ppSet[0][pwd_pkg::PP_MODE_BIT] && $rose(push_pull_out_a));
  c_led_pulse: cover property ($rose(ledDrvOe) && st_reg.ledSet != pwd_pkg::LED_WIDTH_SETTING_FULL);

endmodule // pwd_drivers

// ### logic/pwd_pkg.sv
// constants shared by the pulse-width driver block: register map, field layout,
// reset values and timing tables; assumes a single 250 MHz clock.
//
// Behaviour
// - high-current open-drain output is active only while control bit 7 is 1.
// - 3-bit frequency code selects 23.4 down to 0.75 kHz for the open-drain output.
// - 4-bit duty code n gives (n+1) x 6.25 percent duty.
// - two identical push-pull outputs, controlled at 0x5a and 0x5c.
// - both push-pull control registers reset to 0x00.
// - push-pull mode 0 emits one pulse per 250 Hz period.
// - mode 0 on time is setting/32 ms; setting 127 means always on.
// - mode 1 uses bit 6 for range, bits 5:3 on time, bits 2:0 off time.
// - range 0 gives on times 31 to 244 us and off 0.49 to 5 ms.
// - range 1 gives on times 5 to 60 ms and off 40 to 180 ms.
// - LED open-drain output width set by an 8-bit, 256-step setting.
// - LED on time split into evenly spaced pulses, repeating at 125 Hz.
// - LED settings up to 175 give total on time of setting/22 ms; settings 176 to 254 saturate to full on.
// - LED setting 255 holds the LED output continuously on.
package pwd_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_LED_WIDTH = 8'h59;
  localparam logic [7:0] ADDR_PP_A_CTRL = 8'h5a;
  localparam logic [7:0] ADDR_HC_CTRL = 8'h5b;
  localparam logic [7:0] ADDR_PP_B_CTRL = 8'h5c;
  localparam logic [7:0] RST_LED_WIDTH = 8'h00;
  localparam logic [7:0] RST_PP_A_CTRL = 8'h00;
  localparam logic [7:0] RST_HC_CTRL = 8'h00;
  localparam logic [7:0] RST_PP_B_CTRL = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int HC_EN_BIT = 7;
  localparam int HC_FREQ_LSB = 4;
  localparam int HC_DUTY_LSB = 0;
  localparam int PP_MODE_BIT = 7;
  localparam int PP_RANGE_BIT = 6;
  localparam int PP_ON_LSB = 3;
  localparam int PP_OFF_LSB = 0;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ_DEF = 250_000_000;
  localparam int CNT_W = 27;
  localparam int HC_SLOTS = 16;
  localparam int HC_FREQ_HZ [8] = '{23400, 11700, 6700, 4500, 3000, 2300, 1500, 750};
  localparam int PP_RATE_HZ = 250;
  localparam int PP_SET_DIV = 32;
  localparam logic [6:0] PP_SET_FULL = 7'h7f;
  localparam int PP_ON0_US [8] = '{31, 61, 92, 122, 153, 183, 214, 244};
  localparam int PP_OFF0_US [8] = '{490, 1010, 1500, 2010, 2500, 2990, 4000, 5000};
  localparam int PP_ON1_US [8] = '{5000, 10000, 15000, 20000, 30000, 40000, 50000, 60000};
  localparam int PP_OFF1_US [8] = '{40000, 60000, 80000, 100000, 120000, 140000, 160000,
                                    180000};
  localparam int LED_RATE_HZ = 125;
  localparam int LED_WIDTH_SETTING_DIV = 22;
  localparam int LED_SUBS = 16;
  localparam logic [7:0] LED_WIDTH_SETTING_FULL = 8'hff;

  function automatic int us2cyc(int us, int clkHz);
    return int'((longint'(us) * longint'(clkHz)) / 64'sd1000000);
  endfunction

endpackage

// ### logic/pwd_tick_div.sv
// cycle divider: counts clock cycles and pulses tick once every load cycles.
// assumes load is at least 2 and is only changed while clear is high or at a tick.
module pwd_tick_div #(
  parameter int CNT_W = 17
) (
  input wire logic ref_clk, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic clear, // hold the count at zero
  input wire logic [CNT_W-1:0] load, // cycles per tick
  output logic [CNT_W-1:0] count, // cycles since the last tick
  output logic tick // one-cycle pulse at the end of each interval
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } pwd_div_state_t;

  pwd_div_state_t st_reg;
  pwd_div_state_t st_next;
  logic atEnd;

  assign atEnd = (st_reg.cnt == load - CNT_W'(1));
  assign tick = atEnd && !clear;
  assign count = st_reg.cnt;

  always_comb begin
    st_next = st_reg;
    if (clear || atEnd) begin
      st_next.cnt = '0;
    end else begin
      st_next.cnt = st_reg.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule // pwd_tick_div

// ### sim/pwd_load_model.sv
// load model for the four pulse-width outputs: open-drain pins are resolved
// through pull-ups, then every active and idle run is measured in cycles.
// assumes the outputs only change just after rising edges of ref_clk.
module pwd_load_model (
  input wire logic ref_clk, // system clock
  input wire logic hcDrvOut, // high-current pin value
  input wire logic hcDrvOe, // high-current pin sinking
  input wire logic push_pull_out_a, // push-pull output a
  input wire logic push_pull_out_b, // push-pull output b
  input wire logic ledDrvOut, // LED pin value
  input wire logic ledDrvOe, // LED pin sinking
  output logic [3:0] act, // load energised: hc, a, b, led
  output logic [3:0][31:0] onLen, // length of the last active run
  output logic [3:0][31:0] offLen, // length of the last idle run
  output logic [3:0][31:0] rises // active runs started so far
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] run [4];
  logic [3:0] actQ;
  logic hcPin;
  logic ledPin;

  // released open-drain pins float up, so an undriven pin never reads as sinking
  assign hcPin = hcDrvOe ? hcDrvOut : 1'b1;
  assign ledPin = ledDrvOe ? ledDrvOut : 1'b1;
  assign act = {~ledPin, push_pull_out_b, push_pull_out_a, ~hcPin};

  initial begin
    actQ = 4'h0;
    for (int c = 0; c < 4; c++) begin
      run[c] = 32'h0;
      onLen[c] = 32'h0;
      offLen[c] = 32'h0;
      rises[c] = 32'h0;
    end
  end

  always @(posedge ref_clk) begin
    for (int c = 0; c < 4; c++) begin
      if (act[c] !== actQ[c]) begin
        if (act[c]) begin
          offLen[c] <= run[c];
          rises[c] <= rises[c] + 32'h1;
        end else begin
          onLen[c] <= run[c];
        end
        run[c] <= 32'h1;
      end else begin
        run[c] <= run[c] + 32'h1;
      end
    end
    actQ <= act;
  end
endmodule // pwd_load_model

// ### sim/testbench.sv
// self-checking bench for pwd_drivers with a slowed clock parameter.
// assumes the load model measures pulse runs on all four outputs.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // a low clock figure keeps every period short except the range 1 push-pull ones, while all loads stay >= 2
  localparam int CLK = 1_000_000;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [7:0] regRdData;
  logic hcDrvOut, hcDrvOe, push_pull_out_a, push_pull_out_b, ledDrvOut, ledDrvOe;
  logic [3:0] act;
  logic [3:0][31:0] onLen;
  logic [3:0][31:0] offLen;
  logic [3:0][31:0] rises;
  int nMismatch = 0;
  int nCompared = 0;

  always #2 ref_clk = ~ref_clk;

  pwd_drivers #(.CLK_HZ(CLK)) uut (.ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .hcDrvOut(hcDrvOut), .hcDrvOe(hcDrvOe), .push_pull_out_a(push_pull_out_a),
    .push_pull_out_b(push_pull_out_b), .ledDrvOut(ledDrvOut), .ledDrvOe(ledDrvOe));

  pwd_load_model load (.ref_clk(ref_clk), .hcDrvOut(hcDrvOut), .hcDrvOe(hcDrvOe),
    .push_pull_out_a(push_pull_out_a), .push_pull_out_b(push_pull_out_b),
    .ledDrvOut(ledDrvOut), .ledDrvOe(ledDrvOe), .act(act), .onLen(onLen),
    .offLen(offLen), .rises(rises));

  task automatic conclude();
    $display("compared %0d mismatched %0d", nCompared, nMismatch);
    if (nMismatch == 0 && nCompared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      nMismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge ref_clk);
    regWrEn <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge ref_clk);
    regRdEn <= 1'b0;
    @(posedge ref_clk);
    #1 d = regRdData;
  endtask

  // three fresh pulses: the second lies wholly after the period boundary
  task automatic measure(input int c, input int expOn, input int expOff);
    logic [31:0] base;
    int k;
    base = rises[c];
    k = 0;
    while (rises[c] < base + 32'h3 && k < 40000) begin
      @(posedge ref_clk);
      k++;
    end
    check(rises[c] - base, 32'h3);
    check(onLen[c], 32'(expOn));
    check(offLen[c], 32'(expOff));
  endtask

  task automatic steady(input int c, input int cycles, input logic lvl);
    logic [31:0] base;
    base = rises[c];
    repeat (cycles) @(posedge ref_clk);
    check(rises[c] - base, 32'h0);
    check(32'(act[c]), 32'(lvl));
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_regs();
    logic [7:0] d;
    logic [7:0] a;
    for (int i = 0; i < 4; i++) begin
      a = 8'h59 + 8'(i);
      rd(a, d);
      check(d, 8'h00);
      wr(a, a ^ 8'h3c);
      rd(a, d);
      check(d, a ^ 8'h3c);
      wr(a, 8'h00);
    end
    wr(8'h5d, 8'hff);
    rd(8'h5d, d);
    check(d, 8'h00);
  endtask

  task automatic test_hc();
    int slot;
    wr(8'h5b, 8'h07);
    steady(0, 300, 1'b0);
    check(32'(act[0]), 32'h0);
    for (int f = 0; f < 8; f++) begin
      slot = CLK / (16 * pwd_pkg::HC_FREQ_HZ[f]);
      wr(8'h5b, {1'b1, 3'(f), 4'(f)});
      measure(0, (f + 1) * slot, (15 - f) * slot);
    end
    wr(8'h5b, 8'h8f);
    repeat (3000) @(posedge ref_clk);
    steady(0, 200, 1'b1);
    wr(8'h5b, 8'h0f);
    repeat (2) @(posedge ref_clk);
    check(32'(hcDrvOe), 32'h0);
    check(32'(hcDrvOut), 32'h0);
  endtask

  task automatic test_pp();
    int on;
    logic [31:0] base;
    on = 32 * CLK / 1000 / 32;
    wr(8'h5a, 8'h20);
    wr(8'h5c, 8'hb8);
    measure(1, on, CLK / 250 - on);
    measure(2, pwd_pkg::PP_ON0_US[7] * (CLK / 1_000_000),
            pwd_pkg::PP_OFF0_US[0] * (CLK / 1_000_000));
    // long range: one on run only, the off time would outlast the run budget
    base = rises[2];
    wr(8'h5c, 8'hc0);
    repeat (6600) @(posedge ref_clk);
    check(rises[2] - base, 32'h1);
    check(onLen[2], 32'(pwd_pkg::PP_ON1_US[0] * (CLK / 1_000_000)));
    check(32'(act[2]), 32'h0);
  endtask

  task automatic test_led();
    int on;
    on = 22 * CLK / 1000 / (22 * 16);
    wr(8'h59, 8'h16);
    measure(3, on, CLK / (125 * 16) - on);
  endtask

  task automatic test_full();
    wr(8'h5a, 8'h7f);
    wr(8'h59, 8'hff);
    repeat (9000) @(posedge ref_clk);
    steady(1, 4100, 1'b1);
    steady(3, 600, 1'b1);
  endtask

  initial begin
    repeat (90000) @(posedge ref_clk);
    nMismatch++;
    conclude();
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    test_regs();
    test_hc();
    test_pp();
    test_led();
    test_full();
    conclude();
  end
endmodule // testbench
